// ===== core/pcnp_target_path.sv
`timescale 1ns/100ps
`default_nettype none

module pcnp_target_path #(
    parameter int unsigned          LAT_CLKS  = pcnp_pkg::LAT_CLKS_DEF,
    parameter pcnp_pkg::pcnp_word_t XLAT_BASE = 32'h0000_0000,
    parameter pcnp_pkg::pcnp_word_t XLAT_MASK = 32'h000F_FFFF
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // configuration
    input  wire logic                  single_cycle_only,
    // target controller side
    input  wire pcnp_pkg::pcnp_treq_t  treq,
    output var  pcnp_pkg::pcnp_tresp_t tresp,
    // ordering against system-to-pci writes
    input  wire logic                  s2p_wr_pending,
    // system-side master port
    output var  pcnp_pkg::pcnp_mreq_t  mreq,
    input  wire logic                  m_waitrequest,
    input  wire logic                  m_rdatavalid,
    input  wire pcnp_pkg::pcnp_word_t  m_rdata
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (LAT_CLKS < 2 || LAT_CLKS >= (1 << pcnp_pkg::TMR_W)) begin : g_bad_lat
        $error("pcnp_target_path: LAT_CLKS out of range");
    end

    localparam pcnp_pkg::pcnp_tmr_t LAT_M1 = pcnp_pkg::pcnp_tmr_t'(LAT_CLKS - 1);

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    pcnp_pkg::pcnp_state_t q;
    pcnp_pkg::pcnp_state_t d;
    logic                  routed;
    logic                  is_rd;
    logic                  is_wr;
    logic                  cmd_match;
    logic                  expired;
    pcnp_pkg::pcnp_word_t  xlat_addr;

    // single-cycle profile folds prefetch windows into this path
    assign routed = (treq.hit == pcnp_pkg::HIT_NP) || (treq.hit == pcnp_pkg::HIT_IO) ||
                    (treq.hit == pcnp_pkg::HIT_PREF && single_cycle_only);

    // every read command is one kind here
    assign is_rd = (treq.cmd == pcnp_pkg::CMD_IO_RD) || (treq.cmd == pcnp_pkg::CMD_MEM_RD) ||
                   (treq.cmd == pcnp_pkg::CMD_RD_MUL) || (treq.cmd == pcnp_pkg::CMD_RD_LN);

    // write-and-invalidate is a plain write on this path
    assign is_wr = (treq.cmd == pcnp_pkg::CMD_MEM_WR) || (treq.cmd == pcnp_pkg::CMD_WR_INV) ||
                   (treq.cmd == pcnp_pkg::CMD_IO_WR);

    // a repeat must match all three fields, or it counts as a stranger
    assign cmd_match = (treq.cmd == q.cmd) && (treq.addr == q.addr) && (treq.be == q.be);

    // a level, not a pulse: the counter parks on the limit
    assign expired = (q.tmr == LAT_M1);

    // window offset onto the system-side base
    assign xlat_addr = XLAT_BASE | (treq.addr & XLAT_MASK);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d               = q;
        d.tresp.valid   = 1'b0;
        d.tresp.retry   = 1'b0;
        d.tresp.disc    = 1'b0;
        d.tresp.abort   = 1'b0;
        d.tresp.data_ok = 1'b0;

        // saturates, so expiry stays visible until the read is dropped
        if (q.st != pcnp_pkg::ST_IDLE && q.st != pcnp_pkg::ST_WR && !expired) begin
            d.tmr = q.tmr + 1'b1;
        end

        unique case (q.st)
            pcnp_pkg::ST_IDLE: begin
            end
            pcnp_pkg::ST_WR: begin
                if (!m_waitrequest) begin
                    d.mreq.write = 1'b0;
                    d.st         = pcnp_pkg::ST_IDLE;
                end
            end
            pcnp_pkg::ST_RD_REQ: begin
                if (!m_waitrequest) begin
                    d.mreq.read = 1'b0;
                    d.st        = pcnp_pkg::ST_RD_WT;
                end
            end
            pcnp_pkg::ST_RD_WT: begin
                // the system read must finish before the register is freed
                if (m_rdatavalid) begin
                    // data that arrives too late is dropped, never offered
                    d.tresp.rdata = expired ? pcnp_pkg::RST_WORD : m_rdata;
                    d.st          = expired ? pcnp_pkg::ST_IDLE : pcnp_pkg::ST_RD_HLD;
                end
            end
            pcnp_pkg::ST_RD_HLD: begin
                if (expired) begin
                    d.st          = pcnp_pkg::ST_IDLE;
                    d.tresp.rdata = pcnp_pkg::RST_WORD;
                end
            end
        endcase

        if (treq.start && routed && (is_rd || is_wr)) begin
            d.tresp.valid = 1'b1;
            // decode outcome is final, so abort wins over a busy retry
            if (is_wr && treq.hit == pcnp_pkg::HIT_IO && treq.io_abort) begin
                d.tresp.abort = 1'b1;
            end else if (q.st != pcnp_pkg::ST_IDLE) begin
                if (is_rd && q.st == pcnp_pkg::ST_RD_HLD && cmd_match && !expired &&
                    !s2p_wr_pending) begin
                    d.tresp.data_ok = 1'b1;
                    d.tresp.disc    = 1'b1;
                    d.st            = pcnp_pkg::ST_IDLE;
                end else begin
                    // nothing of the refused request is kept
                    d.tresp.retry = 1'b1;
                end
            end else if (is_wr) begin
                d.cmd         = treq.cmd;
                d.addr        = treq.addr;
                d.be          = treq.be;
                d.tresp.disc  = 1'b1;
                d.mreq.write  = 1'b1;
                d.mreq.addr   = xlat_addr;
                d.mreq.be     = treq.be;
                d.mreq.wdata  = treq.wdata;
                d.st          = pcnp_pkg::ST_WR;
            end else begin
                d.cmd         = treq.cmd;
                d.addr        = treq.addr;
                d.be          = treq.be;
                d.tresp.retry = 1'b1;
                d.mreq.read   = 1'b1;
                d.mreq.addr   = xlat_addr;
                d.mreq.be     = treq.be;
                d.tmr         = pcnp_pkg::RST_TMR;
                d.st          = pcnp_pkg::ST_RD_REQ;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q.st            <= pcnp_pkg::ST_IDLE;
            q.cmd           <= pcnp_pkg::RST_CMD;
            q.addr          <= pcnp_pkg::RST_WORD;
            q.be            <= pcnp_pkg::RST_BE;
            q.tmr           <= pcnp_pkg::RST_TMR;
            q.tresp.valid   <= 1'b0;
            q.tresp.retry   <= 1'b0;
            q.tresp.disc    <= 1'b0;
            q.tresp.abort   <= 1'b0;
            q.tresp.data_ok <= 1'b0;
            q.tresp.rdata   <= pcnp_pkg::RST_WORD;
            q.mreq.write    <= 1'b0;
            q.mreq.read     <= 1'b0;
            q.mreq.addr     <= pcnp_pkg::RST_WORD;
            q.mreq.be       <= pcnp_pkg::RST_BE;
            q.mreq.wdata    <= pcnp_pkg::RST_WORD;
        end else begin
            q <= d;
        end
    end

    assign tresp = q.tresp;
    assign mreq  = q.mreq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_wr_disconnect: assert property (
        treq.start && routed && is_wr && !treq.io_abort && q.st == pcnp_pkg::ST_IDLE
        |=> tresp.valid && tresp.disc && !tresp.retry && mreq.write)
        else $error("accepted write lacks disconnect or system write");

    a_wr_one_cycle: assert property (
        mreq.write && !m_waitrequest |=> !mreq.write && q.st == pcnp_pkg::ST_IDLE)
        else $error("system write not single");

    a_wr_addr_xlat: assert property (
        treq.start && routed && is_wr && !treq.io_abort && q.st == pcnp_pkg::ST_IDLE
        |=> mreq.addr == (XLAT_BASE | ($past(treq.addr) & XLAT_MASK))
            && mreq.wdata == $past(treq.wdata))
        else $error("write address or data wrong");

    a_busy_retry: assert property (
        treq.start && routed && is_wr && !(treq.hit == pcnp_pkg::HIT_IO && treq.io_abort)
        && q.st != pcnp_pkg::ST_IDLE |=> tresp.retry && !tresp.disc && $stable(q.addr))
        else $error("busy write not retried");

    a_no_mem_abort: assert property (
        treq.start && treq.hit != pcnp_pkg::HIT_IO |=> !tresp.abort)
        else $error("abort on memory write");

    a_io_abort: assert property (
        treq.start && routed && is_wr && treq.hit == pcnp_pkg::HIT_IO && treq.io_abort
        |=> tresp.abort && !tresp.disc && !tresp.retry && $stable(q.addr))
        else $error("io abort missing");

    a_rd_latch_retry: assert property (
        treq.start && routed && is_rd && q.st == pcnp_pkg::ST_IDLE
        |=> tresp.retry && mreq.read && q.st == pcnp_pkg::ST_RD_REQ && q.tmr == '0)
        else $error("read request not latched and retried");

    a_rd_mismatch: assert property (
        treq.start && routed && is_rd && q.st != pcnp_pkg::ST_IDLE && !cmd_match
        |=> tresp.retry && !tresp.data_ok && $stable(q.cmd))
        else $error("mismatched read not retried");

    a_rd_order: assert property (
        tresp.data_ok |-> $past(s2p_wr_pending) == 1'b0 && $past(q.st) == pcnp_pkg::ST_RD_HLD)
        else $error("read completed past pending write");

    a_rd_release: assert property (
        tresp.data_ok |-> tresp.disc && q.st == pcnp_pkg::ST_IDLE
                          && tresp.rdata == $past(q.tresp.rdata))
        else $error("completion without release");

    a_lat_expiry: assert property (
        q.st == pcnp_pkg::ST_RD_HLD && expired |=> q.st == pcnp_pkg::ST_IDLE && !tresp.data_ok)
        else $error("held data kept past latency limit");

    a_tmr_count: assert property (
        q.st == pcnp_pkg::ST_RD_HLD && !expired |=> q.tmr == $past(q.tmr) + 1'b1
        || q.st == pcnp_pkg::ST_IDLE)
        else $error("latency counter stalled");

    a_answer_next: assert property (
        treq.start && routed && (is_rd || is_wr) |=> tresp.valid)
        else $error("claimed request not answered next cycle");

    a_no_stray_answer: assert property (
        !(treq.start && routed && (is_rd || is_wr)) |=> !tresp.valid)
        else $error("answer without a claimed request");

    a_cmd_ignored: assert property (
        treq.start && !(is_rd || is_wr) |=> !tresp.valid && $stable(q.cmd))
        else $error("unsupported command touched the path");

    a_one_outcome: assert property (
        tresp.valid |-> $onehot({tresp.retry, tresp.disc, tresp.abort}))
        else $error("answer carries no single termination");

    a_quiet_flags: assert property (
        !tresp.valid |-> !(tresp.retry || tresp.disc || tresp.abort || tresp.data_ok))
        else $error("termination flag without valid");

    a_wr_hold: assert property (
        mreq.write && m_waitrequest |=> mreq.write && $stable(mreq.addr)
            && $stable(mreq.wdata) && $stable(mreq.be))
        else $error("stalled system write changed");

    a_wr_be_pass: assert property (
        treq.start && routed && is_wr && !treq.io_abort && q.st == pcnp_pkg::ST_IDLE
        |=> mreq.be == $past(treq.be))
        else $error("write byte enables altered");

    a_rd_hold: assert property (
        mreq.read && m_waitrequest |=> mreq.read && $stable(mreq.addr) && $stable(mreq.be))
        else $error("stalled system read changed");

    a_one_master: assert property (
        !(mreq.write && mreq.read))
        else $error("system read and write at once");

    a_idle_quiet: assert property (
        q.st == pcnp_pkg::ST_IDLE |-> !mreq.write && !mreq.read)
        else $error("system request while path idle");

    a_rd_capture: assert property (
        q.st == pcnp_pkg::ST_RD_WT && m_rdatavalid && !expired
        |=> q.st == pcnp_pkg::ST_RD_HLD && tresp.rdata == $past(m_rdata))
        else $error("read data not held");

    a_wt_expiry: assert property (
        q.st == pcnp_pkg::ST_RD_WT && m_rdatavalid && expired
        |=> q.st == pcnp_pkg::ST_IDLE && tresp.rdata == pcnp_pkg::RST_WORD)
        else $error("late read data kept");

    a_tmr_start: assert property (
        $rose(mreq.read) |-> q.tmr == pcnp_pkg::RST_TMR)
        else $error("latency counter not cleared at latch");

    a_rd_early: assert property (
        treq.start && routed && is_rd && cmd_match
        && (q.st == pcnp_pkg::ST_RD_REQ || q.st == pcnp_pkg::ST_RD_WT)
        |=> tresp.retry && !tresp.data_ok)
        else $error("read completed before data");

    // ----------------------------------------------------------------
    // scenarios reached
    // ----------------------------------------------------------------
    c_write: cover property (tresp.valid && tresp.disc && !tresp.data_ok ##[1:20] !mreq.write);
    c_read_done: cover property (tresp.retry && mreq.read ##[1:60] tresp.data_ok);
    c_io_abort: cover property (tresp.abort);
    c_order_wait: cover property (q.st == pcnp_pkg::ST_RD_HLD && s2p_wr_pending && tresp.retry);
    c_expiry: cover property (q.st == pcnp_pkg::ST_RD_HLD && expired);

endmodule

`default_nettype wire

// ===== inc/pcnp_pkg.sv
package pcnp_pkg;

    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W       = 32;
    localparam int unsigned BE_W         = 4;
    localparam int unsigned TMR_W        = 24;
    localparam int unsigned LAT_CLKS_DEF = 32768;

    typedef logic [ADDR_W-1:0] pcnp_word_t;
    typedef logic [BE_W-1:0]   pcnp_be_t;
    typedef logic [TMR_W-1:0]  pcnp_tmr_t;

    // ----------------------------------------------------------------
    // bus command codes
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_IO_RD  = 4'h2;
    localparam logic [3:0] CMD_IO_WR  = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_RD_MUL = 4'hC;
    localparam logic [3:0] CMD_RD_LN  = 4'hE;
    localparam logic [3:0] CMD_WR_INV = 4'hF;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam pcnp_word_t RST_WORD = 32'h0000_0000;
    localparam pcnp_be_t   RST_BE   = 4'h0;
    localparam logic [3:0] RST_CMD  = 4'h0;
    localparam pcnp_tmr_t  RST_TMR  = 24'h00_0000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        HIT_NONE = 2'b00,
        HIT_NP   = 2'b01,
        HIT_PREF = 2'b10,
        HIT_IO   = 2'b11
    } pcnp_hit_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_WR     = 3'b001,
        ST_RD_REQ = 3'b010,
        ST_RD_WT  = 3'b011,
        ST_RD_HLD = 3'b100
    } pcnp_st_t;

    typedef struct packed {
        logic       start;
        logic [3:0] cmd;
        pcnp_word_t addr;
        pcnp_be_t   be;
        pcnp_hit_t  hit;
        logic       io_abort;
        pcnp_word_t wdata;
    } pcnp_treq_t;

    typedef struct packed {
        logic       valid;
        logic       retry;
        logic       disc;
        logic       abort;
        logic       data_ok;
        pcnp_word_t rdata;
    } pcnp_tresp_t;

    typedef struct packed {
        logic       write;
        logic       read;
        pcnp_word_t addr;
        pcnp_be_t   be;
        pcnp_word_t wdata;
    } pcnp_mreq_t;

    typedef struct packed {
        pcnp_st_t    st;
        logic [3:0]  cmd;
        pcnp_word_t  addr;
        pcnp_be_t    be;
        pcnp_tmr_t   tmr;
        pcnp_tresp_t tresp;
        pcnp_mreq_t  mreq;
    } pcnp_state_t;

endpackage

// ===== testbench/pcnp_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

module pcnp_mem_model (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // pacing chosen by the bench
    input  wire logic [3:0]           stall,
    input  wire logic [7:0]           rd_lat,
    // system-side slave port
    input  wire pcnp_pkg::pcnp_mreq_t mreq,
    output logic                      m_waitrequest,
    output logic                      m_rdatavalid,
    output pcnp_pkg::pcnp_word_t      m_rdata
);
    int                   wr_count;
    int                   wcnt;
    int                   rcnt;
    logic                 pend;
    pcnp_pkg::pcnp_word_t last_addr;
    pcnp_pkg::pcnp_word_t last_data;
    pcnp_pkg::pcnp_be_t   last_be;
    pcnp_pkg::pcnp_word_t last_raddr;

    // each request is stalled afresh, so a held request never slips through twice
    assign m_waitrequest = (mreq.write | mreq.read) && (wcnt < int'(stall));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_count     <= 0;
            wcnt         <= 0;
            rcnt         <= 0;
            pend         <= 1'b0;
            m_rdatavalid <= 1'b0;
            m_rdata      <= 32'h0000_0000;
        end else begin
            m_rdatavalid <= 1'b0;
            // data line not held outside the valid pulse
            m_rdata      <= ~m_rdata;
            if ((mreq.write | mreq.read) && !m_waitrequest) begin
                wcnt <= 0;
                if (mreq.write) begin
                    wr_count  <= wr_count + 1;
                    last_addr <= mreq.addr;
                    last_data <= mreq.wdata;
                    last_be   <= mreq.be;
                end
                if (mreq.read) begin
                    pend       <= 1'b1;
                    rcnt       <= 0;
                    last_raddr <= mreq.addr;
                end
            end else if (mreq.write | mreq.read) begin
                wcnt <= wcnt + 1;
            end
            if (pend) begin
                if (rcnt >= int'(rd_lat)) begin
                    pend         <= 1'b0;
                    m_rdatavalid <= 1'b1;
                    m_rdata      <= last_raddr ^ 32'h5A5A_0000;
                end else begin
                    rcnt <= rcnt + 1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ===== testbench/pcnp_target_path_bench.sv
`timescale 1ns/100ps
`default_nettype none

module pcnp_target_path_bench;

    // ----------------------------------------------------------------
    // setup
    // ----------------------------------------------------------------
    // short latency count keeps the expiry case quick
    localparam int unsigned          LAT   = 40;
    localparam pcnp_pkg::pcnp_word_t MSK   = 32'h000F_FFFF;
    localparam logic [31:0]          NONE  = 32'h0000_0000;
    localparam logic [31:0]          RETRY = 32'h0000_0018;
    localparam logic [31:0]          DISC  = 32'h0000_0014;
    localparam logic [31:0]          ABORT = 32'h0000_0012;
    localparam logic [31:0]          DATA  = 32'h0000_0015;

    logic                  ref_clk           = 1'b0;
    logic                  rst_n             = 1'b0;
    logic                  single_cycle_only = 1'b1;
    logic                  s2p_wr_pending    = 1'b0;
    pcnp_pkg::pcnp_treq_t  treq              = '0;
    logic [3:0]            stall             = 4'h2;
    logic [7:0]            rd_lat            = 8'h02;
    pcnp_pkg::pcnp_tresp_t tresp;
    pcnp_pkg::pcnp_mreq_t  mreq;
    logic                  m_waitrequest;
    logic                  m_rdatavalid;
    pcnp_pkg::pcnp_word_t  m_rdata;
    pcnp_pkg::pcnp_tresp_t r;
    int                    err_total         = 0;
    int                    checked           = 0;

    always #2 ref_clk = ~ref_clk;

    pcnp_target_path #(.LAT_CLKS(LAT)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .single_cycle_only(single_cycle_only),
        .treq(treq), .tresp(tresp), .s2p_wr_pending(s2p_wr_pending), .mreq(mreq),
        .m_waitrequest(m_waitrequest), .m_rdatavalid(m_rdatavalid), .m_rdata(m_rdata));

    pcnp_mem_model mdl (
        .ref_clk(ref_clk), .rst_n(rst_n), .stall(stall), .rd_lat(rd_lat), .mreq(mreq),
        .m_waitrequest(m_waitrequest), .m_rdatavalid(m_rdatavalid), .m_rdata(m_rdata));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic close_out;
        if (err_total == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] fl();
        return {27'h0, r.valid, r.retry, r.disc, r.abort, r.data_ok};
    endfunction

    // one request; the answer lands one edge later
    task automatic req(input logic [3:0] c, input pcnp_pkg::pcnp_word_t a,
                       input pcnp_pkg::pcnp_be_t b, input pcnp_pkg::pcnp_hit_t h,
                       input logic ab);
        @(posedge ref_clk);
        treq <= '{1'b1, c, a, b, h, ab, a ^ 32'hFFFF_0000};
        @(posedge ref_clk);
        treq.start <= 1'b0;
        #1 r = tresp;
    endtask

    task automatic wr_seen(input int n0, input pcnp_pkg::pcnp_word_t a,
                           input pcnp_pkg::pcnp_be_t b);
        int k;
        k = 0;
        while (mdl.wr_count == n0 && k < 50) begin
            @(posedge ref_clk);
            k++;
        end
        if (mdl.wr_count == n0) begin
            err_total++;
            close_out();
        end
        repeat (8) @(posedge ref_clk);
        chk("write count", mdl.wr_count, n0 + 1);
        chk("write addr", mdl.last_addr, a & MSK);
        chk("write data", mdl.last_data, a ^ 32'hFFFF_0000);
        chk("write be", {28'h0, mdl.last_be}, {28'h0, b});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_writes;
        logic [3:0]          cmds [4] = '{4'h7, 4'hF, 4'h7, 4'h3};
        pcnp_pkg::pcnp_hit_t hits [4] = '{pcnp_pkg::HIT_NP, pcnp_pkg::HIT_NP,
                                          pcnp_pkg::HIT_PREF, pcnp_pkg::HIT_IO};
        pcnp_pkg::pcnp_word_t a;
        int n;
        for (int i = 0; i < 4; i++) begin
            a = 32'hABC0_0010 + 32'(i * 4);
            stall <= 4'(i + 2);
            n = mdl.wr_count;
            req(cmds[i], a, 4'(i + 3), hits[i], 1'b0);
            chk("write resp", fl(), DISC);
            req(4'h7, a + 32'h100, 4'hF, pcnp_pkg::HIT_NP, 1'b0);
            chk("busy write", fl(), RETRY);
            wr_seen(n, a, 4'(i + 3));
        end
    endtask

    task automatic t_abort_ignore;
        int n;
        n = mdl.wr_count;
        req(4'h3, 32'h0000_0300, 4'hF, pcnp_pkg::HIT_IO, 1'b1);
        chk("io abort", fl(), ABORT);
        repeat (8) @(posedge ref_clk);
        chk("aborted write", mdl.wr_count, n);
        req(4'h7, 32'h0001_0200, 4'hF, pcnp_pkg::HIT_NP, 1'b1);
        chk("mem no abort", fl(), DISC);
        wr_seen(n, 32'h0001_0200, 4'hF);
        req(4'hA, 32'h0000_0010, 4'hF, pcnp_pkg::HIT_NP, 1'b0);
        chk("config ignored", fl(), NONE);
        single_cycle_only <= 1'b0;
        req(4'h6, 32'h0000_0020, 4'hF, pcnp_pkg::HIT_PREF, 1'b0);
        chk("burst window", fl(), NONE);
        single_cycle_only <= 1'b1;
    endtask

    task automatic t_read(input logic [3:0] c, input pcnp_pkg::pcnp_hit_t h,
                          input logic hold);
        pcnp_pkg::pcnp_word_t a;
        int n;
        a = 32'h7730_0040 + {24'h0, c, 4'h0};
        s2p_wr_pending <= hold;
        req(c, a, 4'h5, h, 1'b0);
        chk("read request", fl(), RETRY);
        req(c, a, 4'h5, h, 1'b0);
        chk("early repeat", fl(), RETRY);
        req(c, a, 4'h6, h, 1'b0);
        chk("be mismatch", fl(), RETRY);
        req(4'h7, a, 4'h5, pcnp_pkg::HIT_NP, 1'b0);
        chk("write in read", fl(), RETRY);
        repeat (12) @(posedge ref_clk);
        chk("read addr", mdl.last_raddr, a & MSK);
        if (hold) begin
            req(c, a, 4'h5, h, 1'b0);
            chk("held off", fl(), RETRY);
            s2p_wr_pending <= 1'b0;
        end
        req(c, a, 4'h5, h, 1'b0);
        chk("completion", fl(), DATA);
        chk("read data", r.rdata, (a & MSK) ^ 32'h5A5A_0000);
        n = mdl.wr_count;
        req(4'h7, a, 4'h5, pcnp_pkg::HIT_NP, 1'b0);
        chk("freed", fl(), DISC);
        wr_seen(n, a, 4'h5);
    endtask

    task automatic t_expiry;
        req(4'h6, 32'h0004_0080, 4'hF, pcnp_pkg::HIT_NP, 1'b0);
        chk("read request", fl(), RETRY);
        repeat (LAT + 4) @(posedge ref_clk);
        // stale data must be gone: the repeat starts over
        req(4'h6, 32'h0004_0080, 4'hF, pcnp_pkg::HIT_NP, 1'b0);
        chk("after expiry", fl(), RETRY);
        repeat (12) @(posedge ref_clk);
        req(4'h6, 32'h0004_0080, 4'hF, pcnp_pkg::HIT_NP, 1'b0);
        chk("fresh read", fl(), DATA);
        chk("fresh data", r.rdata, 32'h0004_0080 ^ 32'h5A5A_0000);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1 chk("reset idle", {30'h0, mreq.write | mreq.read, tresp.valid}, NONE);
        t_writes();
        t_abort_ignore();
        t_read(4'h6, pcnp_pkg::HIT_NP, 1'b1);
        t_read(4'hE, pcnp_pkg::HIT_PREF, 1'b0);
        t_read(4'hC, pcnp_pkg::HIT_NP, 1'b0);
        t_read(4'h2, pcnp_pkg::HIT_IO, 1'b0);
        t_expiry();
        close_out();
    end

endmodule

`default_nettype wire
